// File: core/port_cfg_if.sv
// Decoded port configuration passed from the register block to its helpers.
// Assumes one driver, the top module, on the ctl side.
`timescale 1ns/1ps
interface port_cfg_if;
  logic       en;
  logic       cpol;
  logic       spi_master;
  logic       timer_clk;
  logic [4:0] div_half;
  logic       spi_slave;
  logic       ss_ctrl;
  logic       i2c_slave;

  modport ctl (output en, cpol, spi_master, timer_clk, div_half,
               spi_slave, ss_ctrl, i2c_slave);
  modport sink (input en, cpol, spi_master, timer_clk, div_half,
                spi_slave, ss_ctrl, i2c_slave);
endinterface

// File: core/port_pin_ctrl.sv
// Pin takeover, serial reset and clock release decisions.
// Assumes ss_in is the slave-select pin level, synchronous to the clock.
`timescale 1ns/1ps
module port_pin_ctrl (
  port_cfg_if.sink  cfg,
  input  wire logic ss_in,
  output logic      spi_pins,
  output logic      i2c_pins,
  output logic      ss_sel,
  output logic      ss_free,
  output logic      ser_reset,
  output logic      sck_drive,
  output logic      scl_hold
);
  assign spi_pins  = cfg.en &
                     (cfg.spi_master | cfg.spi_slave);
  assign i2c_pins  = cfg.en & cfg.i2c_slave;
  assign ss_sel    = cfg.en & cfg.ss_ctrl;
  assign ss_free   = cfg.en & cfg.spi_slave & ~cfg.ss_ctrl;
  assign ser_reset = ~cfg.en | (cfg.ss_ctrl & ss_in);
  assign sck_drive = cfg.en & cfg.spi_master;
  assign scl_hold  = cfg.en & cfg.i2c_slave & ~cfg.cpol;
endmodule

// File: core/spi_clock_gen.sv
// Serial clock generator for master modes, with leading and trailing strobes.
// Assumes timer_tick is a one-cycle pulse synchronous to sys_clk.
`timescale 1ns/1ps
module spi_clock_gen (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  port_cfg_if.sink  cfg,
  input  wire logic xfer_active,
  input  wire logic timer_tick,
  output logic      sck_lvl,
  output logic      lead_stb,
  output logic      trail_stb
);
  logic       run;
  logic       tick;
  logic       phase_r;
  logic [4:0] cnt_r;

  assign run  = cfg.en & cfg.spi_master & xfer_active;
  assign tick = cfg.timer_clk ? timer_tick : (cnt_r == cfg.div_half - 5'h01);

  // ==========================================================
  // Divider counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (!run || tick) begin
      cnt_r <= 5'h00;
    end else begin
      cnt_r <= cnt_r + 5'h01;
    end
  end

  // ==========================================================
  // Clock phase and edge strobes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r   <= 1'b0;
      lead_stb  <= 1'b0;
      trail_stb <= 1'b0;
    end else begin
      phase_r   <= run ? (phase_r ^ tick) : 1'b0;
      lead_stb  <= run & tick & ~phase_r;
      trail_stb <= run & tick & phase_r;
    end
  end

  assign sck_lvl = cfg.cpol ^ phase_r;  // Clock level; polarity gives the idle level
endmodule

// File: core/sync_serial_mode_control.sv
// Control register block of a synchronous serial port in SPI or I2C role.
// Assumes an APB master on the register side; pins are sync to sys_clk.
//
// Notes on behaviour
// - Overflow flag is sticky; only software clears it, transmit ignores it.
// - SPI mode with port enabled takes over clock, data out, data in pins.
// - I2C mode with port enabled takes over SDA and SCL pins.
// - Clearing the enable bit hands all pins back to general port use.
// - Polarity one: clock idles high, shift on falling, sample on rising.
// - Polarity zero: clock idles low, shift on rising, sample on falling.
// - Code 0011 gives SPI master clocked by timer output over two.
// - Code 0100 gives SPI slave on clock pin with slave select used.
// - SPI slave with select used resets serial logic while select high.
// - Code 0101 gives SPI slave with select pin free for general use.
// - Codes 0110, 0111 give I2C slave, 7 or 10 bit, no start/stop irq.
// - Code 1110 gives I2C slave, 7 bit, with start/stop interrupts.
// - Code 1111 gives I2C slave, 10 bit, with start/stop interrupts.
// - Code 1011 gives firmware I2C master; hardware slave stays idle.
`timescale 1ns/1ps
module sync_serial_mode_control (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        overflow_evt,
  input  wire logic        collision_evt,
  input  wire logic        xfer_active,
  input  wire logic        timer_tick,
  input  wire logic        ss_in,
  output logic             spi_pins_sel,
  output logic             i2c_pins_sel,
  output logic             ss_pin_sel,
  output logic             ss_pin_free,
  output logic             spi_slave_active,
  output logic             serial_reset,
  output logic             sck_o,
  output logic             sck_oe,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             tx_shift_stb,
  output logic             rx_sample_stb,
  output logic             i2c_slave_active,
  output logic             addr_10bit,
  output logic             start_stop_irq_en,
  output logic             fw_master_active
);

  // ==========================================================
  // Declarations
  logic [5:0]  cfg_r;
  logic        ovf_r;
  logic        wcol_r;
  logic [3:0]  mode;
  logic        access;
  logic        hit_ctl;
  logic        hit_stat;
  logic        wr_ctl;
  logic        rsvd;
  logic        fw_mst;
  logic [7:0]  ctl_view;
  logic [7:0]  stat_view;
  logic [31:0] rd_nxt;
  logic        gen_sck;
  logic        gen_lead;
  logic        gen_trail;
  logic        p_spi;
  logic        p_i2c;
  logic        p_ss;
  logic        p_ss_free;
  logic        p_reset;
  logic        p_sck_drv;
  logic        p_scl_hold;

  port_cfg_if cfg ();

  // ==========================================================
  // APB decode
  assign access   = psel & penable;
  assign hit_ctl  = paddr == sync_serial_pkg::CTRL_ADDR;
  assign hit_stat = paddr == sync_serial_pkg::STAT_ADDR;
  assign wr_ctl   = access & pready & pwrite & hit_ctl;

  // ==========================================================
  // Mode decode
  assign mode   = cfg_r[sync_serial_pkg::MODE_MSB:0];
  assign fw_mst = mode == sync_serial_pkg::MODE_I2C_FWM;
  assign rsvd   = ~sync_serial_pkg::is_spi_master(mode) &
                  ~sync_serial_pkg::is_i2c_slave(mode) & ~fw_mst &
                  (mode != sync_serial_pkg::MODE_SLV_SS) &
                  (mode != sync_serial_pkg::MODE_SLV_NOSS);

  assign cfg.en         = cfg_r[sync_serial_pkg::EN_BIT];
  assign cfg.cpol       = cfg_r[sync_serial_pkg::CPOL_BIT];
  assign cfg.spi_master = sync_serial_pkg::is_spi_master(mode);
  assign cfg.timer_clk  = mode == sync_serial_pkg::MODE_SPI_TMR;
  assign cfg.spi_slave  = (mode == sync_serial_pkg::MODE_SLV_SS) |
                          (mode == sync_serial_pkg::MODE_SLV_NOSS);
  assign cfg.ss_ctrl    = mode == sync_serial_pkg::MODE_SLV_SS;
  assign cfg.i2c_slave  = sync_serial_pkg::is_i2c_slave(mode);

  // Divider selection
  always_comb begin
    case (mode)
      sync_serial_pkg::MODE_SPI_DIV16:
        cfg.div_half = sync_serial_pkg::HALF_DIV16;
      sync_serial_pkg::MODE_SPI_DIV64:
        cfg.div_half = sync_serial_pkg::HALF_DIV64;
      default:
        cfg.div_half = sync_serial_pkg::HALF_DIV4;
    endcase
  end

  // ==========================================================
  // Read views
  assign ctl_view = {wcol_r, ovf_r, cfg_r};
  always_comb begin
    stat_view                             = 8'h00;
    stat_view[sync_serial_pkg::ST_SPI_MST] = cfg.spi_master;
    stat_view[sync_serial_pkg::ST_SPI_SLV] = cfg.spi_slave;
    stat_view[sync_serial_pkg::ST_I2C_SLV] = cfg.i2c_slave;
    stat_view[sync_serial_pkg::ST_FW_MST]  = fw_mst;
    stat_view[sync_serial_pkg::ST_RSVD]    = rsvd;
    stat_view[sync_serial_pkg::ST_SS_PIN]  = ss_in;
    stat_view[sync_serial_pkg::ST_SCK_LVL] = sck_o;
  end

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (hit_ctl) begin
      rd_nxt = {24'h00_0000, ctl_view};
    end else if (hit_stat) begin
      rd_nxt = {24'h00_0000, stat_view};
    end
  end

  // ==========================================================
  // APB answer, one wait state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~(hit_ctl | hit_stat);
      if (access & ~pready & ~pwrite) begin
        prdata <= rd_nxt;
      end
    end
  end

  // ==========================================================
  // Control fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= sync_serial_pkg::CTRL_RESET[5:0];
    end else if (wr_ctl) begin
      cfg_r <= pwdata[5:0];
    end
  end

  // ==========================================================
  // Sticky flags, set wins over software clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_r  <= sync_serial_pkg::CTRL_RESET[sync_serial_pkg::OVF_BIT];
      wcol_r <= sync_serial_pkg::CTRL_RESET[sync_serial_pkg::WCOL_BIT];
    end else begin
      ovf_r  <= overflow_evt |
                (wr_ctl ? pwdata[sync_serial_pkg::OVF_BIT] : ovf_r);
      wcol_r <= collision_evt |
                (wr_ctl ? pwdata[sync_serial_pkg::WCOL_BIT] : wcol_r);
    end
  end

  // ==========================================================
  // Helpers
  spi_clock_gen u_clk (
    .sys_clk     (sys_clk),
    .rst_n       (rst_n),
    .cfg         (cfg.sink),
    .xfer_active (xfer_active),
    .timer_tick  (timer_tick),
    .sck_lvl     (gen_sck),
    .lead_stb    (gen_lead),
    .trail_stb   (gen_trail)
  );

  port_pin_ctrl u_pins (
    .cfg       (cfg.sink),
    .ss_in     (ss_in),
    .spi_pins  (p_spi),
    .i2c_pins  (p_i2c),
    .ss_sel    (p_ss),
    .ss_free   (p_ss_free),
    .ser_reset (p_reset),
    .sck_drive (p_sck_drv),
    .scl_hold  (p_scl_hold)
  );

  // ==========================================================
  // Pin and engine outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_pins_sel     <= 1'b0;
      i2c_pins_sel     <= 1'b0;
      ss_pin_sel       <= 1'b0;
      ss_pin_free      <= 1'b0;
      spi_slave_active <= 1'b0;
      serial_reset     <= 1'b1;
      sck_oe           <= 1'b0;
      scl_o            <= 1'b0;
      scl_oe           <= 1'b0;
    end else begin
      spi_pins_sel     <= p_spi;
      i2c_pins_sel     <= p_i2c | (cfg.en & fw_mst);
      ss_pin_sel       <= p_ss;
      ss_pin_free      <= p_ss_free;
      spi_slave_active <= cfg.en & cfg.spi_slave;
      serial_reset     <= p_reset;
      sck_oe           <= p_sck_drv;
      scl_o            <= 1'b0;
      scl_oe           <= p_scl_hold;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_o         <= 1'b0;
      tx_shift_stb  <= 1'b0;
      rx_sample_stb <= 1'b0;
    end else begin
      sck_o         <= gen_sck;
      tx_shift_stb  <= gen_lead;
      rx_sample_stb <= gen_trail;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      i2c_slave_active  <= 1'b0;
      addr_10bit        <= 1'b0;
      start_stop_irq_en <= 1'b0;
      fw_master_active  <= 1'b0;
    end else begin
      i2c_slave_active  <= cfg.en & cfg.i2c_slave;
      addr_10bit        <= cfg.en & cfg.i2c_slave &
                           mode[0];
      start_stop_irq_en <= cfg.en &
                           ((cfg.i2c_slave & mode[3]) | fw_mst);
      fw_master_active  <= cfg.en & fw_mst;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence quiet_s;
    (!xfer_active && $stable(cfg_r))[*3];
  endsequence

  sequence div4_run_s;
    (cfg.en && mode == sync_serial_pkg::MODE_SPI_DIV4 && xfer_active &&
     $stable(cfg_r))[*5];
  endsequence

  ovf_sticky_a : assert property (
    ovf_r && !(wr_ctl && !pwdata[sync_serial_pkg::OVF_BIT]) |=> ovf_r)
    else $error("overflow flag lost without a clear");

  ovf_set_a : assert property (overflow_evt |=> ovf_r)
    else $error("overflow event did not set flag");

  spi_pins_a : assert property (
    cfg.en && (cfg.spi_master || cfg.spi_slave) |=> spi_pins_sel)
    else $error("spi pins not taken while enabled");

  i2c_pins_a : assert property (
    cfg.en && cfg.i2c_slave |=> i2c_pins_sel && !spi_pins_sel)
    else $error("i2c pins not taken while enabled");

  pins_release_a : assert property (
    !cfg.en |=> !spi_pins_sel && !i2c_pins_sel && !sck_oe && serial_reset)
    else $error("pins still held while disabled");

  sck_idle_a : assert property (
    quiet_s |-> sck_o == cfg_r[sync_serial_pkg::CPOL_BIT])
    else $error("serial clock not at idle level");

  lead_edge_a : assert property (
    tx_shift_stb && $stable(cfg_r) |->
      sck_o != cfg_r[sync_serial_pkg::CPOL_BIT] && $changed(sck_o))
    else $error("shift strobe not on leading edge");

  trail_edge_a : assert property (
    rx_sample_stb && $stable(cfg_r) |->
      sck_o == cfg_r[sync_serial_pkg::CPOL_BIT] && $changed(sck_o))
    else $error("sample strobe not on trailing edge");

  div4_period_a : assert property (
    tx_shift_stb ##0 div4_run_s |-> tx_shift_stb)
    else $error("divide by four period wrong");

  ss_reset_a : assert property (
    cfg.en && mode == sync_serial_pkg::MODE_SLV_SS && ss_in |=> serial_reset)
    else $error("slave select high did not reset");

  scl_hold_a : assert property (
    cfg.en && cfg.i2c_slave |=> scl_oe == !$past(cfg.cpol))
    else $error("scl stretch wrong for polarity");

  fw_idle_a : assert property (
    cfg.en && fw_mst |=> fw_master_active && !i2c_slave_active)
    else $error("slave not idle in firmware master");

  irq_mode_a : assert property (
    cfg.en && mode == sync_serial_pkg::MODE_I2C_7_SP |=>
      start_stop_irq_en && !addr_10bit)
    else $error("start stop enable wrong in 7 bit mode");

  fw_pins_a : assert property (
    cfg.en && fw_mst |=> i2c_pins_sel && !scl_oe && !i2c_slave_active)
    else $error("i2c pins not taken in firmware master");

  ss_free_a : assert property (
    cfg.en && mode == sync_serial_pkg::MODE_SLV_NOSS |=>
      ss_pin_free && !ss_pin_sel && !serial_reset)
    else $error("select pin not freed in slave mode");

  master_oe_a : assert property (
    cfg.en && cfg.spi_master |=> sck_oe && spi_pins_sel && !i2c_pins_sel)
    else $error("serial clock not driven in master mode");

  irq_10bit_a : assert property (
    cfg.en && mode == sync_serial_pkg::MODE_I2C_10_SP |=>
      start_stop_irq_en && addr_10bit && i2c_slave_active)
    else $error("start stop enable wrong in 10 bit mode");

  ovf_clear_a : assert property (
    wr_ctl && !pwdata[sync_serial_pkg::OVF_BIT] && !overflow_evt |=> !ovf_r)
    else $error("overflow flag not cleared by software");

endmodule

// File: core/sync_serial_pkg.sv
// Constants, mode codes and decode helpers of the serial port control block.
// Assumes a 32-bit APB register bus and a 50 MHz system clock.
package sync_serial_pkg;

  // ==========================================================
  // Register map
  localparam logic [11:0] CTRL_ADDR  = 12'h014;
  localparam logic [11:0] STAT_ADDR  = 12'h018;
  localparam logic [7:0]  CTRL_RESET = 8'h00;

  // ==========================================================
  // Control field layout
  localparam int WCOL_BIT = 7;
  localparam int OVF_BIT  = 6;
  localparam int EN_BIT   = 5;
  localparam int CPOL_BIT = 4;
  localparam int MODE_MSB = 3;

  // ==========================================================
  // Status field layout
  localparam int ST_SPI_MST = 0;
  localparam int ST_SPI_SLV = 1;
  localparam int ST_I2C_SLV = 2;
  localparam int ST_FW_MST  = 3;
  localparam int ST_RSVD    = 4;
  localparam int ST_SS_PIN  = 5;
  localparam int ST_SCK_LVL = 6;

  // ==========================================================
  // Mode codes
  localparam logic [3:0] MODE_SPI_DIV4  = 4'h0;
  localparam logic [3:0] MODE_SPI_DIV16 = 4'h1;
  localparam logic [3:0] MODE_SPI_DIV64 = 4'h2;
  localparam logic [3:0] MODE_SPI_TMR   = 4'h3;
  localparam logic [3:0] MODE_SLV_SS    = 4'h4;
  localparam logic [3:0] MODE_SLV_NOSS  = 4'h5;
  localparam logic [3:0] MODE_I2C_7     = 4'h6;
  localparam logic [3:0] MODE_I2C_10    = 4'h7;
  localparam logic [3:0] MODE_I2C_FWM   = 4'hb;
  localparam logic [3:0] MODE_I2C_7_SP  = 4'he;
  localparam logic [3:0] MODE_I2C_10_SP = 4'hf;

  // ==========================================================
  // Clock dividers, full periods and half periods in system clocks
  localparam int DIV4  = 4;
  localparam int DIV16 = 16;
  localparam int DIV64 = 64;
  localparam logic [4:0] HALF_DIV4  = 5'(DIV4 / 2);
  localparam logic [4:0] HALF_DIV16 = 5'(DIV16 / 2);
  localparam logic [4:0] HALF_DIV64 = 5'(DIV64 / 2 - 1) + 5'h01;

  // ==========================================================
  // Decode helpers
  function automatic logic is_spi_master(input logic [3:0] m);
    return m[3:2] == 2'b00;
  endfunction

  function automatic logic is_i2c_slave(input logic [3:0] m);
    return (m == MODE_I2C_7) || (m == MODE_I2C_10) ||
           (m == MODE_I2C_7_SP) || (m == MODE_I2C_10_SP);
  endfunction

endpackage

// File: testbench/serial_peer.sv
// Far-side peer of the serial port: select driver, SCL pull-up, clock timer.
// Assumes the clock and pin outputs of the port are synchronous to sys_clk.
`timescale 1ns/1ps
module serial_peer (
  input  wire logic       sys_clk,
  input  wire logic       sck_o,
  input  wire logic       sck_oe,
  input  wire logic       scl_o,
  input  wire logic       scl_oe,
  input  wire logic       ss_req,
  output logic            ss_in,
  output logic            scl_line,
  output logic      [7:0] period
);
  logic [7:0] gap_r = 8'h00;
  logic       last_r = 1'b0;

  // ==========================================================
  // Pins
  // Peer master drives the select line
  assign ss_in = ss_req;
  // Open drain line with pull-up; pin left as input
  assign scl_line = (scl_oe === 1'b1) ? scl_o : 1'b1;

  // ==========================================================
  // Clock period between rising edges
  always @(negedge sys_clk) begin
    last_r <= sck_o;
    if (sck_oe === 1'b1 && sck_o === 1'b1 && last_r === 1'b0) begin
      period <= gap_r + 8'h01;
      gap_r  <= 8'h00;
    end else begin
      gap_r  <= gap_r + 8'h01;
    end
  end
endmodule

// File: testbench/test_sync_serial_mode_control.sv
// Self-checking bench of the serial port control block.
// Assumes the package and design files are compiled first.
`timescale 1ns/1ps
module test_sync_serial_mode_control;
  localparam int TICK  = 5;
  localparam int LIMIT = 20000;
  logic        sys_clk, rst_n, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, w, o, e;
  logic        pready, pslverr, overflow_evt, collision_evt, xfer_active;
  logic        timer_tick, ss_in, ss_req, err, cur_cp;
  logic        spi_pins_sel, i2c_pins_sel, ss_pin_sel, ss_pin_free;
  logic        spi_slave_active, serial_reset, sck_o, sck_oe, scl_o;
  logic        scl_oe, tx_shift_stb, rx_sample_stb, i2c_slave_active;
  logic        addr_10bit, start_stop_irq_en, fw_master_active, scl_line;
  logic [7:0]  period;
  logic [12:0] obs;
  int          bad_count, tests_run, cycles, tick_cnt, seed;

  sync_serial_mode_control dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .overflow_evt(overflow_evt),
    .collision_evt(collision_evt), .xfer_active(xfer_active),
    .timer_tick(timer_tick), .ss_in(ss_in), .spi_pins_sel(spi_pins_sel),
    .i2c_pins_sel(i2c_pins_sel), .ss_pin_sel(ss_pin_sel),
    .ss_pin_free(ss_pin_free), .spi_slave_active(spi_slave_active),
    .serial_reset(serial_reset), .sck_o(sck_o), .sck_oe(sck_oe),
    .scl_o(scl_o), .scl_oe(scl_oe), .tx_shift_stb(tx_shift_stb),
    .rx_sample_stb(rx_sample_stb), .i2c_slave_active(i2c_slave_active),
    .addr_10bit(addr_10bit), .start_stop_irq_en(start_stop_irq_en),
    .fw_master_active(fw_master_active));

  serial_peer peer (
    .sys_clk(sys_clk), .sck_o(sck_o), .sck_oe(sck_oe), .scl_o(scl_o),
    .scl_oe(scl_oe), .ss_req(ss_req), .ss_in(ss_in),
    .scl_line(scl_line), .period(period));

  assign obs = {scl_line, spi_pins_sel, i2c_pins_sel, ss_pin_sel,
                ss_pin_free, spi_slave_active, serial_reset, sck_oe, scl_oe,
                i2c_slave_active, addr_10bit, start_stop_irq_en,
                fw_master_active};

  // ==========================================================
  // Clock, timer ticks, timeout
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    tick_cnt   <= (tick_cnt == TICK - 1) ? 0 : tick_cnt + 1;
    timer_tick <= (tick_cnt == TICK - 1);
    cycles     <= cycles + 1;
    if (cycles == LIMIT) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Expectations
  function automatic logic [12:0] exp_pins(input logic [3:0] m,
                                           input logic en, cp, ss);
    logic i2cs;
    i2cs = (m == 4'h6) || (m == 4'h7) || (m == 4'he) || (m == 4'hf);
    return {!(en && i2cs && !cp), en && m < 4'h6, en && (i2cs || m == 4'hb),
            en && m == 4'h4, en && m == 4'h5, en && (m == 4'h4 || m == 4'h5),
            !en || (m == 4'h4 && ss), en && m < 4'h4, en && i2cs && !cp,
            en && i2cs, en && (m == 4'h7 || m == 4'hf),
            en && (m == 4'he || m == 4'hf || m == 4'hb), en && m == 4'hb};
  endfunction

  function automatic logic [7:0] exp_per(input int m);
    return (m == 0) ? 8'(sync_serial_pkg::DIV4) :
           (m == 1) ? 8'(sync_serial_pkg::DIV16) :
           (m == 2) ? 8'(sync_serial_pkg::DIV64) : 8'(2 * TICK);
  endfunction

  function automatic logic [31:0] exp_stat(input logic [3:0] m,
                                           input logic cp, ss);
    logic i2cs;
    i2cs = (m == 4'h6) || (m == 4'h7) || (m == 4'he) || (m == 4'hf);
    return {25'h0, cp, ss, m[3] && !i2cs && m != 4'hb, m == 4'hb, i2cs,
            m == 4'h4 || m == 4'h5, m < 4'h4};
  endfunction

  // ==========================================================
  // Bus, compare and closing tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // Strobe polarity monitor
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1 && tx_shift_stb === 1'b1)
      chk({31'h0, sck_o}, {31'h0, ~cur_cp});
    if (rst_n === 1'b1 && rx_sample_stb === 1'b1)
      chk({31'h0, sck_o}, {31'h0, cur_cp});
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hc74a9aa5;
    {rst_n, psel, penable, pwrite, overflow_evt, collision_evt} = 6'h00;
    {xfer_active, cur_cp} = 2'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ss_req = 1'b1;
    {bad_count, tests_run, cycles, tick_cnt} = '0;
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Reset value and unmapped place
    apb(1'b0, sync_serial_pkg::CTRL_ADDR, 32'h0);
    chk(rd, {24'h0, sync_serial_pkg::CTRL_RESET});
    apb(1'b1, 12'h020, 32'h0000_00ff);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, 12'h020, 32'h0);
    chk({rd[31:1], err}, 32'h1);
    apb(1'b0, sync_serial_pkg::CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    // Every mode code, enabled and not, reserved codes too
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 16; m++)
        for (int en = 0; en < 2; en++) begin
          w = $random(seed);
          w[5] = en[0];
          w[3:0] = m[3:0];
          ss_req <= w[8];
          apb(1'b1, sync_serial_pkg::CTRL_ADDR, w);
          settle(3);
          o = {19'h0, obs};
          e = {19'h0, exp_pins(m[3:0], en[0], w[4], w[8])};
          chk(o & 32'h0c00, e & 32'h0c00);
          chk(o & 32'h03c0, e & 32'h03c0);
          chk(o & 32'h1010, e & 32'h1010);
          chk(o & 32'h0020, e & 32'h0020);
          chk(o & 32'h000c, e & 32'h000c);
          chk(o & 32'h0003, e & 32'h0003);
          if (en == 1 && m < 4)
            chk({31'h0, sck_o}, {31'h0, w[4]});
          apb(1'b0, sync_serial_pkg::CTRL_ADDR, 32'h0);
          chk(rd, {24'h0, w[7:0]});
          apb(1'b0, sync_serial_pkg::STAT_ADDR, 32'h0);
          chk(rd, exp_stat(m[3:0], w[4], w[8]));
        end
    // Sticky flags kept until software clears them
    apb(1'b1, sync_serial_pkg::CTRL_ADDR, 32'h26);
    overflow_evt  <= 1'b1;
    collision_evt <= 1'b1;
    @(posedge sys_clk);
    overflow_evt  <= 1'b0;
    collision_evt <= 1'b0;
    settle(10);
    apb(1'b0, sync_serial_pkg::CTRL_ADDR, 32'h0);
    chk(rd, 32'he6);
    apb(1'b1, sync_serial_pkg::CTRL_ADDR, 32'h26);
    apb(1'b0, sync_serial_pkg::CTRL_ADDR, 32'h0);
    chk(rd, 32'h26);
    // Master clock rates and idle levels
    for (int m = 0; m < 4; m++)
      for (int cp = 0; cp < 2; cp++) begin
        cur_cp = cp[0];
        apb(1'b1, sync_serial_pkg::CTRL_ADDR, {26'h0, 1'b1, cp[0], m[3:0]});
        xfer_active <= 1'b1;
        settle(300);
        chk({24'h0, period}, {24'h0, exp_per(m)});
        @(posedge sys_clk);
        xfer_active <= 1'b0;
        settle(3);
        chk({31'h0, sck_o}, {31'h0, cur_cp});
      end
    tally_and_finish();
  end
endmodule
